// [hw/rx_port_link_status.sv]
module rx_port_link_status
#(
  parameter int PORTS = rx_status_pkg::NUM_PORTS
)
(
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic       [7:0] reg_addr,
  input  wire logic       [7:0] reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic            [7:0] reg_rdata,
  input  wire logic [PORTS-1:0] rx_locked,
  input  wire logic [PORTS-1:0] rx_pass,
  input  wire logic [PORTS-1:0] parity_over_limit,
  input  wire logic [PORTS-1:0] csi_rx_err,
  input  wire logic [PORTS-1:0] no_link_clk,
  input  wire logic [PORTS-1:0] link_expected,
  input  wire logic [PORTS-1:0] freq_measure_settled,
  input  wire logic [PORTS-1:0] ctrl_chan_crc_err,
  input  wire logic [PORTS-1:0] ctrl_chan_seq_err,
  input  wire logic [PORTS-1:0] line_length_unsteady,
  input  wire logic [PORTS-1:0] line_length_changed,
  input  wire logic [PORTS-1:0] link_encoding_err,
  input  wire logic [PORTS-1:0] buffer_overflow,
  input  wire logic [PORTS-1:0] line_count_changed,
  input  wire logic [PORTS*8-1:0] freq_integer_mhz,
  input  wire logic [PORTS*8-1:0] freq_fraction
);
  ////////////////////////////////////////////////////////////////////////
  // port select
  logic       read_port_q;
  logic       read_port_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       rd_one_sel;
  logic       rd_two_sel;
  logic [PORTS-1:0] lock_s1_q;
  logic [PORTS-1:0] lock_s2_q;
  logic [3:0] one_f [PORTS];
  logic [4:0] two_f [PORTS];

  always_comb
  begin
    read_port_d = read_port_q;
    if (reg_wr && reg_addr == rx_status_pkg::PORT_SEL_ADDR)
      read_port_d = reg_wdata[rx_status_pkg::READ_PORT_BIT];
  end

  assign rd_one_sel = reg_rd && reg_addr == rx_status_pkg::STATUS_ONE_ADDR;
  assign rd_two_sel = reg_rd && reg_addr == rx_status_pkg::STATUS_TWO_ADDR;

  ////////////////////////////////////////////////////////////////////////
  // per port flags
  genvar g;
  generate
    for (g = 0; g < PORTS; g++)
    begin : g_port
      rx_port_flags u_flags
      (
        .core_clk    (core_clk),
        .rst         (rst),
        .rx_locked   (lock_s2_q[g]),
        .crc_ev      (ctrl_chan_crc_err[g]),
        .seq_ev      (ctrl_chan_seq_err[g]),
        .unsteady_ev (line_length_unsteady[g]),
        .len_chg_ev  (line_length_changed[g]),
        .enc_ev      (link_encoding_err[g]),
        .buf_ev      (buffer_overflow[g]),
        .cnt_chg_ev  (line_count_changed[g]),
        .rd_one      (rd_one_sel && read_port_q == 1'(g)),
        .rd_two      (rd_two_sel && read_port_q == 1'(g)),
        .one_flags   (one_f[g]),
        .two_flags   (two_f[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb
  begin
    logic p;
    p = read_port_q;
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      rdata_d = 8'h00;
      case (reg_addr)
        rx_status_pkg::PORT_SEL_ADDR:
          rdata_d[rx_status_pkg::READ_PORT_BIT] = read_port_q;
        rx_status_pkg::STATUS_ONE_ADDR:
        begin
          rdata_d[rx_status_pkg::S1_PORT_NUM] = read_port_q;
          rdata_d[rx_status_pkg::S1_CRC]      = one_f[p][3];
          rdata_d[rx_status_pkg::S1_LOCK_CHG] = one_f[p][2];
          rdata_d[rx_status_pkg::S1_SEQ]      = one_f[p][1];
          rdata_d[rx_status_pkg::S1_PARITY]   =
            parity_over_limit[p];
          rdata_d[rx_status_pkg::S1_PASS]     = rx_pass[p];
          rdata_d[rx_status_pkg::S1_LOCK]     = lock_s2_q[p];
        end
        rx_status_pkg::STATUS_TWO_ADDR:
        begin
          rdata_d[rx_status_pkg::S2_LEN_UNST] = two_f[p][4];
          rdata_d[rx_status_pkg::S2_LEN_CHG]  = two_f[p][3];
          rdata_d[rx_status_pkg::S2_ENC]      = two_f[p][2];
          rdata_d[rx_status_pkg::S2_BUF]      = two_f[p][1];
          rdata_d[rx_status_pkg::S2_CSI]      = csi_rx_err[p];
          rdata_d[rx_status_pkg::S2_FREQ_OK]  =
            freq_measure_settled[p];
          rdata_d[rx_status_pkg::S2_CABLE]    =
            no_link_clk[p] & link_expected[p];
          rdata_d[rx_status_pkg::S2_CNT_CHG]  = two_f[p][0];
        end
        rx_status_pkg::FREQ_INT_ADDR:
          rdata_d = freq_integer_mhz[p*8 +: 8];
        rx_status_pkg::FREQ_FRAC_ADDR:
          rdata_d = freq_fraction[p*8 +: 8];
        default:
          rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      read_port_q <= 1'b0;
      rdata_q     <= rx_status_pkg::RESET_VALUE;
      lock_s1_q   <= '0;
      lock_s2_q   <= '0;
    end
    else
    begin
      read_port_q <= read_port_d;
      rdata_q     <= rdata_d;
      lock_s1_q   <= rx_locked;
      lock_s2_q   <= lock_s1_q;
    end
  end

  assign reg_rdata = rdata_q;

  property p_port_num;
    @(posedge core_clk) disable iff (rst)
      rd_one_sel |=> reg_rdata[rx_status_pkg::S1_PORT_NUM] == $past(read_port_q);
  endproperty
  a_port_num: assert property (p_port_num)
    else $error("bad port num");

  property p_sel;
    @(posedge core_clk) disable iff (rst)
      (reg_wr && reg_addr == rx_status_pkg::PORT_SEL_ADDR)
        |=> read_port_q == $past(reg_wdata[rx_status_pkg::READ_PORT_BIT]);
  endproperty
  a_sel: assert property (p_sel)
    else $error("select not taken");

  property p_lock;
    @(posedge core_clk) disable iff (rst)
      rd_one_sel |=> reg_rdata[rx_status_pkg::S1_LOCK]
        == $past(lock_s2_q[read_port_q]);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit wrong");

  property p_freq;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == rx_status_pkg::FREQ_INT_ADDR && !read_port_q)
        |=> reg_rdata == $past(freq_integer_mhz[7:0]);
  endproperty
  a_freq: assert property (p_freq)
    else $error("freq wrong");

  ////////////////////////////////////////////////////////////////////////
  // live level and read data checks
  property p_pass;
    @(posedge core_clk) disable iff (rst)
      rd_one_sel |=> reg_rdata[rx_status_pkg::S1_PASS]
        == $past(rx_pass[read_port_q]);
  endproperty
  a_pass: assert property (p_pass)
    else $error("pass bit wrong");

  property p_parity;
    @(posedge core_clk) disable iff (rst)
      rd_one_sel |=> reg_rdata[rx_status_pkg::S1_PARITY]
        == $past(parity_over_limit[read_port_q]);
  endproperty
  a_parity: assert property (p_parity)
    else $error("parity bit wrong");

  property p_csi;
    @(posedge core_clk) disable iff (rst)
      rd_two_sel |=> reg_rdata[rx_status_pkg::S2_CSI]
        == $past(csi_rx_err[read_port_q]);
  endproperty
  a_csi: assert property (p_csi)
    else $error("csi bit wrong");

  property p_settled;
    @(posedge core_clk) disable iff (rst)
      rd_two_sel |=> reg_rdata[rx_status_pkg::S2_FREQ_OK]
        == $past(freq_measure_settled[read_port_q]);
  endproperty
  a_settled: assert property (p_settled)
    else $error("settled bit wrong");

  property p_cable;
    @(posedge core_clk) disable iff (rst)
      rd_two_sel |=> reg_rdata[rx_status_pkg::S2_CABLE]
        == $past(no_link_clk[read_port_q] & link_expected[read_port_q]);
  endproperty
  a_cable: assert property (p_cable)
    else $error("cable bit wrong");

  property p_frac;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr == rx_status_pkg::FREQ_FRAC_ADDR)
        |=> reg_rdata == $past(freq_fraction[read_port_q*8 +: 8]);
  endproperty
  a_frac: assert property (p_frac)
    else $error("fraction wrong");

  property p_unmapped;
    @(posedge core_clk) disable iff (rst)
      (reg_rd && reg_addr > rx_status_pkg::FREQ_FRAC_ADDR)
        |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_stands;
    @(posedge core_clk) disable iff (rst)
      !reg_rd
        |=> $stable(reg_rdata);
  endproperty
  a_stands: assert property (p_stands)
    else $error("read data moved");
endmodule // rx_port_link_status

// [hw/rx_status_pkg.sv]
// How it works
// - one status copy per receive port; reads follow port select
// - status one bit 6 returns the selected read port number
// - status one bit 5 sets on control channel crc error, clears on read
// - status one bit 4 sets on any lock change, clears on read
// - status one bit 3 sets on control channel seq error, clears on read
// - status one bit 1 shows live pass state
// - status one bit 0 shows live receiver lock
// - status two bit 6 sets on line length change, clears on read
// - status two bit 5: encoding error, clear on read; sets on any single error
// - status two bit 4 sets on packet buffer overflow, clears on read
// - status two bit 3 shows csi receive error, read only
// - status two bit 1 shows cable fault when no link clock seen and link expected
// - status two bit 0 sets on line count change, clears on read
// - 0x4f holds integer mhz; status two bit 2 shows measurement settled
// - 0x50 holds fraction of frequency in 1/256 mhz
// - read port select bit: 0 picks port 0, 1 picks port 1
package rx_status_pkg;
  localparam logic [7:0] PORT_SEL_ADDR   = 8'h4C;
  localparam logic [7:0] STATUS_ONE_ADDR = 8'h4D;
  localparam logic [7:0] STATUS_TWO_ADDR = 8'h4E;
  localparam logic [7:0] FREQ_INT_ADDR   = 8'h4F;
  localparam logic [7:0] FREQ_FRAC_ADDR  = 8'h50;
  localparam int         READ_PORT_BIT   = 4;
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam int         NUM_PORTS       = 2;
  // status one positions
  localparam int S1_PORT_NUM = 6;
  localparam int S1_CRC      = 5;
  localparam int S1_LOCK_CHG = 4;
  localparam int S1_SEQ      = 3;
  localparam int S1_PARITY   = 2;
  localparam int S1_PASS     = 1;
  localparam int S1_LOCK     = 0;
  // status two positions
  localparam int S2_LEN_UNST = 7;
  localparam int S2_LEN_CHG  = 6;
  localparam int S2_ENC      = 5;
  localparam int S2_BUF      = 4;
  localparam int S2_CSI      = 3;
  localparam int S2_FREQ_OK  = 2;
  localparam int S2_CABLE    = 1;
  localparam int S2_CNT_CHG  = 0;
endpackage

// [hw/rx_port_flags.sv]
module rx_port_flags
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       rx_locked,
  input  wire logic       crc_ev,
  input  wire logic       seq_ev,
  input  wire logic       unsteady_ev,
  input  wire logic       len_chg_ev,
  input  wire logic       enc_ev,
  input  wire logic       buf_ev,
  input  wire logic       cnt_chg_ev,
  input  wire logic       rd_one,
  input  wire logic       rd_two,
  output logic      [3:0] one_flags,
  output logic      [4:0] two_flags
);
  logic [3:0] one_q;
  logic [3:0] one_d;
  logic [4:0] two_q;
  logic [4:0] two_d;
  logic       lock_prev_q;
  logic       lock_chg;

  assign lock_chg = rx_locked ^ lock_prev_q;

  always_comb
  begin
    // set wins over read clear
    one_d = (rd_one ? 4'h0 : one_q)
          | {crc_ev, lock_chg, seq_ev, 1'b0};
    two_d = (rd_two ? 5'h00 : two_q)
          | {unsteady_ev, len_chg_ev, enc_ev, buf_ev,
             cnt_chg_ev};
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      one_q       <= 4'h0;
      two_q       <= 5'h00;
      lock_prev_q <= 1'b0;
    end
    else
    begin
      one_q       <= one_d;
      two_q       <= two_d;
      lock_prev_q <= rx_locked;
    end
  end

  assign one_flags = one_q;
  assign two_flags = two_q;

  property p_crc_sticky;
    @(posedge core_clk) disable iff (rst)
      crc_ev |=> one_q[3];
  endproperty
  a_crc_sticky: assert property (p_crc_sticky)
    else $error("crc flag lost");

  property p_lock_chg;
    @(posedge core_clk) disable iff (rst)
      (rx_locked != $past(rx_locked)) |=> one_q[2];
  endproperty
  a_lock_chg: assert property (p_lock_chg)
    else $error("lock change lost");

  property p_read_clears;
    @(posedge core_clk) disable iff (rst)
      (rd_two && !unsteady_ev) |=> !two_q[4];
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("no clear");

  property p_hold;
    @(posedge core_clk) disable iff (rst)
      (two_q[1] && !rd_two) |=> two_q[1];
  endproperty
  a_hold: assert property (p_hold)
    else $error("buffer flag dropped");
endmodule // rx_port_flags

// [sim/rx_link_peer.sv]
module rx_link_peer
(
  input  wire logic        core_clk,
  input  wire logic        ev_go,
  input  wire logic [13:0] ev_pick,
  input  wire logic [13:0] lvl_pick,
  input  wire logic [31:0] freq_pick,
  output logic      [13:0] lvl,
  output logic      [13:0] ev,
  output logic      [31:0] freq
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    lvl = 14'h0000;
    ev = 14'h0000;
    freq = 32'h0000_0000;
  end
  // live levels and one-cycle event pulses
  always @(negedge core_clk)
  begin
    lvl <= lvl_pick;
    freq <= freq_pick;
    ev <= ev_go ? ev_pick : 14'h0000;
  end
endmodule // rx_link_peer

// [sim/rx_port_link_status_tb.sv]
module rx_port_link_status_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        rst;
  logic  [7:0] reg_addr;
  logic  [7:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic  [7:0] reg_rdata;
  logic        ev_go;
  logic [13:0] ev_pick;
  logic [13:0] lvl_pick;
  logic [31:0] freq_pick;
  logic [13:0] lvl;
  logic [13:0] ev;
  logic [31:0] freq;
  logic  [6:0] st [2];
  logic  [1:0] lc;
  logic  [1:0] pl;
  logic        sel;
  int          seed;
  int          miscompares;
  int          checks;
  ////////////////////////////////////////////////////////////////////////////
  rx_link_peer u_rx_link_peer
  (
    .core_clk(core_clk), .ev_go(ev_go), .ev_pick(ev_pick),
    .lvl_pick(lvl_pick), .freq_pick(freq_pick),
    .lvl(lvl), .ev(ev), .freq(freq)
  );
  rx_port_link_status #(.PORTS(2)) u_rx_port_link_status
  (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_locked(lvl[1:0]), .rx_pass(lvl[3:2]),
    .parity_over_limit(lvl[5:4]), .csi_rx_err(lvl[7:6]),
    .no_link_clk(lvl[9:8]), .link_expected(lvl[11:10]),
    .freq_measure_settled(lvl[13:12]), .ctrl_chan_crc_err(ev[1:0]),
    .ctrl_chan_seq_err(ev[3:2]), .line_length_unsteady(ev[5:4]),
    .line_length_changed(ev[7:6]), .link_encoding_err(ev[9:8]),
    .buffer_overflow(ev[11:10]), .line_count_changed(ev[13:12]),
    .freq_integer_mhz(freq[15:0]), .freq_fraction(freq[31:16])
  );
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic lv(input int t);
    lv = lvl[t*2+int'(sel)];
  endfunction
  function automatic logic [7:0] expv(input logic [7:0] a);
    logic [6:0] s;
    s = st[sel];
    case (a)
      8'h4d: expv = {1'b0, sel, s[0], lc[sel], s[1], lv(2), lv(1), lv(0)};
      8'h4e: expv = {s[2], s[3], s[4], s[5], lv(3), lv(6), lv(4) & lv(5),
                     s[6]};
      8'h4c: expv = {3'h0, sel, 4'h0};
      8'h4f: expv = freq[int'(sel)*8+:8];
      8'h50: expv = freq[16+int'(sel)*8+:8];
      default: expv = 8'h00;
    endcase
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] e;
    e = expv(a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check(reg_rdata, e);
    if (a == 8'h4d)
    begin
      st[sel][1:0] = 2'b00;
      lc[sel] = 1'b0;
    end
    if (a == 8'h4e)
      st[sel][6:2] = 5'b0_0000;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
    if (a == 8'h4c)
      sel = d[4];
  endtask
  task automatic close_out;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial
  begin
    #100000;
    miscompares++;
    close_out;
  end
  initial
  begin
    seed = 50583;
    {miscompares, checks} = 0;
    {rst, reg_addr, reg_wdata, reg_wr, reg_rd} = 19'h4_0000;
    {ev_go, ev_pick, lvl_pick, freq_pick} = 61'h0;
    {st[0], st[1], lc, pl, sel} = 19'h0_0000;
    repeat (4) @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < 60; i++)
    begin
      if (i > 0)
      begin
        ev_pick <= 14'($random(seed));
        lvl_pick <= 14'($random(seed));
        freq_pick <= $random(seed);
        ev_go <= (i % 4 != 0);
        @(negedge core_clk);
        ev_go <= 1'b0;
        for (int k = 0; k < 14; k++)
          if (ev_go)
            st[k%2][k/2] = st[k%2][k/2] | ev_pick[k];
        wr(i[0] ? 8'h4c : 8'h4e, 8'($random(seed)));
      end
      repeat (6) @(negedge core_clk);
      lc = lc | (lvl[1:0] ^ pl);
      pl = lvl[1:0];
      rd(8'h4d);
      rd(8'h4e);
      rd(8'h4d);
      rd(8'h4f);
      rd(8'h50);
      rd(8'h51);
      rd(8'h4c);
    end
    // event in the read cycle keeps its flag
    ev_pick <= 14'h0003;
    ev_go <= 1'b1;
    fork
      rd(8'h4d);
      @(negedge core_clk) ev_go <= 1'b0;
    join
    st[0][0] = 1'b1;
    st[1][0] = 1'b1;
    rd(8'h4d);
    close_out;
  end
endmodule // rx_port_link_status_tb
